/* File: hw/lsr_pkg.sv */
package lsr_pkg;
  // Clock and integration timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned INTEG_MS      = 400;
  localparam int unsigned INTEG_CYC_DEF = INTEG_MS * 1000000 / CLK_PERIOD_NS;

  // Register indices on the serial link
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_THLL = 4'h2;
  localparam logic [3:0] A_THLH = 4'h3;
  localparam logic [3:0] A_THHL = 4'h4;
  localparam logic [3:0] A_THHH = 4'h5;
  localparam logic [3:0] A_ICR  = 4'h6;
  localparam logic [3:0] A_ID   = 4'ha;
  localparam logic [3:0] A_C0L  = 4'hc;
  localparam logic [3:0] A_C0H  = 4'hd;
  localparam logic [3:0] A_C1L  = 4'he;
  localparam logic [3:0] A_C1H  = 4'hf;

  // Bus addresses
  localparam logic [6:0] ARA_ADDR     = 7'h0c;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h39;

  // Identity nibbles; values are arbitrary
  localparam logic [3:0] PART_CODE = 4'ha;
  localparam logic [3:0] REV_CODE  = 4'h6;

  // Field positions
  localparam int STY_HI   = 5;
  localparam int STY_LO   = 4;
  localparam int PER_HI   = 3;
  localparam int CMD_BIT  = 7;
  localparam int CLR_BIT  = 6;
  localparam int WORD_BIT = 5;

  // Field values
  localparam logic [1:0] STY_OFF = 2'h0;
  localparam logic [1:0] STY_LVL = 2'h1;
  localparam logic [1:0] STY_TST = 2'h3;
  localparam logic [1:0] PWR_ON  = 2'h3;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_SEEN  = 4'h9;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_WACK  = 6'h04,
    ST_WRITE = 6'h08,
    ST_READ  = 6'h10,
    ST_RACK  = 6'h20
  } lsr_st_t;

  typedef struct packed {
    logic [15:0] ch1;
    logic [15:0] ch0;
  } lsr_res_t;

  typedef struct packed {
    logic        scl_m, scl_s, scl_p;
    logic        sda_m, sda_s, sda_p;
    lsr_st_t     st;
    logic [3:0]  bitcnt;
    logic [7:0]  sr;
    logic [7:0]  tx;
    logic        rw, first, ara, lost, word;
    logic [3:0]  ptr;
    logic [1:0]  ctrl;
    logic [7:0]  icr;
    logic [15:0] thr_lo;
    logic [15:0] thr_hi;
    lsr_res_t    res;
    logic [7:0]  sh0, sh1;
    logic        pend;
    logic [3:0]  pcnt;
    logic [31:0] icnt;
    logic        sda_oe, irq_oe, run;
  } lsr_state_t;
endpackage

/* File: hw/lsr_top.sv */
`timescale 1ns/1ps
module lsr_top import lsr_pkg::*; #(
  parameter int unsigned INTEG_CYCLES = INTEG_CYC_DEF,
  parameter logic [6:0]  DEV_ADDR     = DEV_ADDR_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic [15:0] adc_ch0_i,
  input  wire logic [15:0] adc_ch1_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             irq_o,
  output logic             irq_oe_o,
  output logic             adc_run_o
);

  lsr_state_t q;
  lsr_state_t n;
  logic       scl_r;
  logic       scl_f;
  logic       start;
  logic       stop;
  logic       load;
  logic       wr_icr;
  logic       conv_now;
  logic       out_win;
  logic [3:0] per;

  // Register read multiplexer; unmapped indices read zero
  function automatic logic [7:0] rd_mux(input logic [3:0] a, input lsr_state_t s);
    case (a)
      A_CTRL:  rd_mux = {6'h00, s.ctrl};
      A_THLL:  rd_mux = s.thr_lo[7:0];
      A_THLH:  rd_mux = s.thr_lo[15:8];
      A_THHL:  rd_mux = s.thr_hi[7:0];
      A_THHH:  rd_mux = s.thr_hi[15:8];
      A_ICR:   rd_mux = s.icr;
      A_ID:    rd_mux = {PART_CODE, REV_CODE};
      A_C0L:   rd_mux = s.res.ch0[7:0];
      A_C0H:   rd_mux = s.sh0;
      A_C1L:   rd_mux = s.res.ch1[7:0];
      A_C1H:   rd_mux = s.sh1;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // Next-state logic: link first, then conversion events, so a set beats a clear
  always_comb begin
    n        = q;
    scl_r    = q.scl_s & ~q.scl_p;
    scl_f    = ~q.scl_s & q.scl_p;
    start    = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    stop     = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    load     = 1'b0;
    wr_icr   = 1'b0;
    conv_now = 1'b0;
    per      = q.icr[PER_HI:0];
    out_win  = (adc_ch0_i <= q.thr_lo) || (adc_ch0_i > q.thr_hi);
    // Pin synchronisers; SCL edges are found on the synced copy only
    n.scl_m  = scl_i;
    n.scl_s  = q.scl_m;
    n.scl_p  = q.scl_s;
    n.sda_m  = sda_i;
    n.sda_s  = q.sda_m;
    n.sda_p  = q.sda_s;
    if (stop) begin
      n.st     = ST_IDLE;
      n.sda_oe = 1'b0;
    end else if (start) begin
      n.st     = ST_ADDR;
      n.bitcnt = 4'h0;
      n.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
        end
        ST_ADDR, ST_WRITE: begin
          if (scl_r && q.bitcnt != BYTE_BITS) begin
            n.sr     = {q.sr[6:0], q.sda_s};
            n.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_f && q.bitcnt == BYTE_BITS) begin
            if (q.st == ST_ADDR) begin
              // Answer the alert response only with a pending interrupt in alert or test style (STY_HI set)
              n.ara    = (q.sr[7:1] == ARA_ADDR) && q.sr[0] && q.pend
                         && q.icr[STY_HI];
              n.rw     = q.sr[0];
              n.first  = 1'b1;
              n.lost   = 1'b0;
              n.st     = (q.sr[7:1] == DEV_ADDR || n.ara) ? ST_WACK : ST_IDLE;
              n.sda_oe = (n.st == ST_WACK);
            end else begin
              n.st     = ST_WACK;
              n.sda_oe = 1'b1;
              n.first  = 1'b0;
              if (q.first && q.sr[CMD_BIT]) begin
                // Command byte sets pointer and word mode, may clear the interrupt
                n.ptr  = q.sr[3:0];
                n.word = q.sr[WORD_BIT];
                if (q.sr[CLR_BIT]) begin
                  n.pend = 1'b0;
                end
              end else begin
                n.ptr = q.word ? q.ptr + 4'h1 : q.ptr;
                case (q.ptr)
                  A_CTRL:  n.ctrl = q.sr[1:0];
                  A_THLL:  n.thr_lo[7:0] = q.sr;
                  A_THLH:  n.thr_lo[15:8] = q.sr;
                  A_THHL:  n.thr_hi[7:0] = q.sr;
                  A_THHH:  n.thr_hi[15:8] = q.sr;
                  A_ICR: begin
                    // Reserved bits are stored as zero whatever the host sends
                    wr_icr = 1'b1;
                    n.icr  = {2'b00, q.sr[5:0]};
                  end
                  default: begin
                  end
                endcase
              end
            end
          end
        end
        ST_WACK: begin
          if (scl_f) begin
            if (q.rw) begin
              load = 1'b1;
            end else begin
              n.st     = ST_WRITE;
              n.bitcnt = 4'h0;
              n.sda_oe = 1'b0;
            end
          end
        end
        ST_READ: begin
          if (scl_r) begin
            n.bitcnt = q.bitcnt + 4'h1;
            // Lost arbitration on the alert answer: back off, keep interrupt
            if (q.ara && q.tx[7] && !q.sda_s) begin
              n.lost   = 1'b1;
              n.sda_oe = 1'b0;
            end
          end else if (scl_f) begin
            if (q.bitcnt == BYTE_BITS) begin
              n.st     = ST_RACK;
              n.sda_oe = 1'b0;
              if (q.ara && !q.lost) begin
                n.pend = 1'b0;
              end
            end else begin
              n.tx     = {q.tx[6:0], 1'b0};
              n.sda_oe = ~q.tx[6] & ~q.lost;
            end
          end
        end
        ST_RACK: begin
          if (scl_r) begin
            n.bitcnt = ACK_SEEN;
            if (q.sda_s) begin
              n.st = ST_IDLE; // Master NACK ends the read
            end
          end else if (scl_f && q.bitcnt == ACK_SEEN) begin
            load = 1'b1;
          end
        end
        default: n.st = ST_IDLE;
      endcase
    end
    // Load the next byte to send, with the read side effects
    if (load) begin
      n.st     = ST_READ;
      n.bitcnt = 4'h0;
      if (q.ara) begin
        n.tx = {DEV_ADDR, 1'b0};
      end else begin
        n.tx  = rd_mux(q.ptr, q);
        n.ptr = q.word ? q.ptr + 4'h1 : q.ptr;
        if (q.ptr == A_C0L) begin
          n.sh0 = q.res.ch0[15:8];
        end
        if (q.ptr == A_C1L) begin
          n.sh1 = q.res.ch1[15:8];
        end
      end
      n.sda_oe = ~n.tx[7];
    end
    // Integration timer runs only while powered up
    if (q.ctrl != PWR_ON) begin
      n.icnt = 32'h0;
    end else if (q.icnt == 32'(INTEG_CYCLES - 1)) begin
      conv_now = 1'b1;
      n.icnt   = 32'h0;
      n.res    = '{ch1: adc_ch1_i, ch0: adc_ch0_i};
      if (per == 4'h0) begin
        n.pend = 1'b1;
      end else if (out_win) begin
        if (q.pcnt + 4'h1 >= per) begin
          n.pend = 1'b1;
          n.pcnt = 4'h0;
        end else begin
          n.pcnt = q.pcnt + 4'h1;
        end
      end else begin
        n.pcnt = 4'h0;
      end
    end else begin
      n.icnt = q.icnt + 32'h1;
    end
    if (wr_icr && q.sr[STY_HI:STY_LO] == STY_TST) begin
      n.pend = 1'b1;
    end
    // Pin driven only when a style is enabled
    n.irq_oe = n.pend && (n.icr[STY_HI:STY_LO] != STY_OFF);
    n.run    = (n.ctrl == PWR_ON);
  end

  // State register; power-down, zero results and style off after reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q    <= '0;
      q.st <= ST_IDLE;
      // Bus pins idle high, so the sync chain starts high: no false edge after reset
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Open-drain pins pull low only
  assign sda_o     = 1'b0;
  assign irq_o     = 1'b0;
  assign sda_oe_o  = q.sda_oe;
  assign irq_oe_o  = q.irq_oe;
  assign adc_run_o = q.run;

  a_style_off: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (q.icr[STY_HI:STY_LO] == STY_OFF) |-> !irq_oe_o)
    else $error("interrupt driven while style is off");

  a_test_mode: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (wr_icr && q.sr[STY_HI:STY_LO] == STY_TST) |=> (q.pend && irq_oe_o))
    else $error("test style did not raise the interrupt");

  a_persist_zero: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (conv_now && per == 4'h0) |=> q.pend)
    else $error("no interrupt at end of conversion");

  a_persist_one: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (conv_now && per == 4'h1 && out_win) |=> q.pend)
    else $error("single out-of-window result missed");

  a_persist_count: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (conv_now && out_win && per > 4'h1 && q.pcnt + 4'h1 < per)
    |=> (q.pcnt == $past(q.pcnt) + 4'h1))
    else $error("persistence count did not advance");

  a_inwin_clear: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (conv_now && !out_win && per != 4'h0) |=> (q.pcnt == 4'h0))
    else $error("in-window result kept the count");

  a_id_const: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (load && !q.ara && q.ptr == A_ID) |=> (q.tx == {PART_CODE, REV_CODE}))
    else $error("identity byte wrong");

  a_shadow_hold: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !(load && q.ptr == A_C0L) |=> $stable(q.sh0))
    else $error("shadow changed without a low byte read");

  a_power_down: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (q.ctrl != PWR_ON) |-> (!conv_now ##1 q.icnt == 32'h0))
    else $error("converting while powered down");

  a_level_hold: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (irq_oe_o && q.icr[STY_HI:STY_LO] == STY_LVL && !(q.st == ST_WRITE && q.first)
     && !wr_icr)
    |=> irq_oe_o)
    else $error("level interrupt dropped without clear");

  a_level_clear: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (scl_f && q.st == ST_WRITE && q.first && q.bitcnt == BYTE_BITS && q.sr[CMD_BIT]
     && q.sr[CLR_BIT] && !conv_now) |=> !q.pend)
    else $error("clear command left the interrupt pending");

  a_alert_clear: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (scl_f && q.st == ST_READ && q.bitcnt == BYTE_BITS && q.ara && !q.lost && !conv_now)
    |=> !q.pend)
    else $error("won alert response left the interrupt pending");

  a_inwin_quiet: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (conv_now && per == 4'h1 && adc_ch0_i > q.thr_lo && adc_ch0_i <= q.thr_hi
     && !q.pend && !wr_icr) |=> !q.pend)
    else $error("in-window result raised the interrupt");

  a_shadow_latch: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (load && !q.ara && q.ptr == A_C1L) |=> (q.sh1 == $past(q.res.ch1[15:8])))
    else $error("shadow missed the upper result byte");

  a_word_step: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (load && !q.ara && q.word) |=> (q.ptr == $past(q.ptr) + 4'h1))
    else $error("word read did not step the pointer");

  a_result_pair: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    conv_now |=> (q.res == {$past(adc_ch1_i), $past(adc_ch0_i)}))
    else $error("result bytes not updated together");

endmodule

/* File: test/lsr_host.sv */
`timescale 1ns/1ps
// Host controller model; the data line is open drain with a pull-up, the clock is driven both high and low
module lsr_host import lsr_pkg::*; #(
  parameter logic [6:0] ADDR = DEV_ADDR_DEF
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  logic scl_low;
  logic nak;
  logic a;
  assign scl_o = ~scl_low;
  initial begin
    scl_low = 1'b0;
    sda_low_o = 1'b0;
  end
  // Every step lands just after a clock edge
  task automatic hp(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Data moves 3 clocks after the fall so it never races the clock edge
  task automatic bit_io(input logic b, output logic r);
    hp(3);
    sda_low_o = ~b;
    hp(3);
    scl_low = 1'b0;
    hp(3);
    r = sda_i;
    hp(4);
    scl_low = 1'b1;
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    hp(3);
    sda_low_o = 1'b0;
    scl_low = 1'b0;
    hp(6);
    sda_low_o = 1'b1;
    hp(6);
    scl_low = 1'b1;
  endtask
  task automatic stop();
    hp(3);
    sda_low_o = 1'b1;
    hp(3);
    scl_low = 1'b0;
    hp(6);
    sda_low_o = 1'b0;
    hp(6);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ak, a);
  endtask
  // Byte sent by the host; a missing acknowledge is remembered
  task automatic wb(input logic [7:0] d);
    logic [7:0] q;
    xfer(d, 1'b1, q);
    nak |= a;
  endtask
  // Command byte, then writes, or a repeated start and reads low byte first
  task automatic txn(input logic [7:0] cmd, input logic [15:0] wd, input int nw,
                     input int nr, output logic [15:0] rd, output logic nk);
    logic [7:0] q;
    nak = 1'b0;
    rd = '0;
    start();
    wb({ADDR, 1'b0});
    wb(cmd);
    for (int i = 0; i < nw; i++) wb(wd[8*i +: 8]);
    if (nr > 0) begin
      start();
      wb({ADDR, 1'b1});
    end
    for (int i = 0; i < nr; i++) begin
      xfer(8'hff, i == nr - 1, q);
      rd[8*i +: 8] = q;
    end
    stop();
    nk = nak;
  endtask
  // Alert response read
  task automatic ara(output logic [7:0] q, output logic nk);
    nak = 1'b0;
    start();
    wb({ARA_ADDR, 1'b1});
    xfer(8'hff, 1'b1, q);
    stop();
    nk = nak;
  endtask
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench import lsr_pkg::*;;
  localparam int unsigned IC = 1000;
  logic        clk;
  logic        rstn;
  logic        scl;
  logic        sda;
  logic        sda_low;
  logic        sda_o;
  logic        sda_oe;
  logic        irq_o;
  logic        irq_oe;
  logic        run;
  logic        irq_n;
  lsr_res_t    adc;
  logic [15:0] rd;
  logic [7:0]  q;
  logic        nk;
  int          bad_count;
  int          n_checks;
  // Wired levels of the open-drain pins
  assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;
  assign irq_n = irq_oe ? irq_o : 1'b1;
  lsr_top #(.INTEG_CYCLES(IC)) dut (
    .clk_i    (clk),
    .rstn_i   (rstn),
    .scl_i    (scl),
    .sda_i    (sda),
    .adc_ch0_i(adc.ch0),
    .adc_ch1_i(adc.ch1),
    .sda_o    (sda_o),
    .sda_oe_o (sda_oe),
    .irq_o    (irq_o),
    .irq_oe_o (irq_oe),
    .adc_run_o(run)
  );
  lsr_host host (
    .clk_i    (clk),
    .sda_i    (sda),
    .scl_o    (scl),
    .sda_low_o(sda_low)
  );
  task automatic wrap_up();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait on the interrupt pin; running out ends the run
  task automatic wait_irq(input logic lvl, input int n);
    for (int i = 0; i < n && irq_n !== lvl; i++) cy(1);
    chk("irq wait", {15'h0, lvl}, {15'h0, irq_n});
    if (irq_n !== lvl) wrap_up();
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
    host.txn(cmd, d, n, 0, rd, nk);
    chk("ack", 16'h0, {15'h0, nk});
  endtask
  task automatic rdc(input string nm, input logic [7:0] cmd, input int n,
                     input logic [15:0] e);
    host.txn(cmd, 16'h0, 0, n, rd, nk);
    chk(nm, e, rd);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Main sequence
  initial begin
    bad_count = 0;
    n_checks = 0;
    rstn = 1'b0;
    adc = '{ch1: 16'h5678, ch0: 16'h1234};
    cy(4);
    rstn = 1'b1;
    cy(3);
    chk("adc run", 16'h0, {15'h0, run});
    rdc("identity", 8'h8a, 1, {8'h00, PART_CODE, REV_CODE});
    wr(8'h8c, 16'h0055, 1);
    rdc("ch0 unpowered", 8'hac, 2, 16'h0000);
    wr(8'h80, 16'h0003, 1);
    chk("adc run", 16'h1, {15'h0, run});
    rdc("power", 8'h80, 1, 16'h0003);
    cy(IC);
    rdc("ch0 word", 8'hac, 2, 16'h1234);
    rdc("ch1 word", 8'hae, 2, 16'h5678);
    rdc("ch1 low", 8'h8e, 1, 16'h0078);
    adc.ch1 = 16'h9abc;
    cy(IC + 20);
    rdc("ch1 shadow", 8'h8f, 1, 16'h0056);
    rdc("ch1 low", 8'h8e, 1, 16'h00bc);
    rdc("ch1 high", 8'h8f, 1, 16'h009a);
    wr(8'ha2, 16'h1000, 2);
    wr(8'ha4, 16'h2000, 2);
    adc = '{ch1: 16'hffff, ch0: 16'h1234};
    wr(8'h86, 16'h0011, 1);
    chk("irq persist zero", 16'h0, {15'h0, irq_n});
    rdc("irq control", 8'h86, 1, 16'h0011);
    // Persistence 0 left a pending flag behind while the style was off
    wr(8'hc0, 16'h0, 0);
    cy(2 * IC);
    chk("irq in window", 16'h1, {15'h0, irq_n});
    adc.ch0 = 16'h1000;
    wait_irq(1'b0, IC + 20);
    wr(8'h86, 16'h0001, 1);
    chk("irq off", 16'h1, {15'h0, irq_n});
    wr(8'h86, 16'h0011, 1);
    chk("irq held", 16'h0, {15'h0, irq_n});
    adc.ch0 = 16'h1234;
    wr(8'hc0, 16'h0, 0);
    chk("irq cleared", 16'h1, {15'h0, irq_n});
    wr(8'h86, 16'h0013, 1);
    adc.ch0 = 16'h2001;
    cy(2 * IC - 10);
    chk("irq persist", 16'h1, {15'h0, irq_n});
    wait_irq(1'b0, IC + 30);
    adc.ch0 = 16'h1234;
    wr(8'hc0, 16'h0, 0);
    wr(8'h86, 16'h0031, 1);
    chk("irq test", 16'h0, {15'h0, irq_n});
    host.ara(q, nk);
    chk("alert addr", {8'h00, DEV_ADDR_DEF, 1'b0}, {8'h00, q});
    cy(8);
    chk("irq alert", 16'h1, {15'h0, irq_n});
    // Plain alert style, raised by the next conversion end
    wr(8'h86, 16'h0020, 1);
    wait_irq(1'b0, IC + 20);
    host.ara(q, nk);
    chk("alert ack", 16'h0, {15'h0, nk});
    cy(8);
    chk("irq alert style", 16'h1, {15'h0, irq_n});
    wrap_up();
  end
endmodule
